// file: verilog/sto_ss1_core.sv
// Purpose: torque-off and time-controlled stop logic with AHB-Lite config
// Assumes: fieldbus command and drive signals on hclk; input pins asynchronous
// Notes:   reset state is torque off; safe input disabled after reset
`timescale 1ns/1ns
module sto_ss1_core #(
  parameter int TICK_CYCLES = sto_ss1_pkg::TICK_CYCLES
) (
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  input  wire logic                           clk_en,
  input  wire logic                           hsel,
  input  wire logic [sto_ss1_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic                                hreadyout,
  output logic [31:0]                         hrdata,
  output logic                                hresp,
  input  wire logic                           chan_a_pin,
  input  wire logic                           chan_b_pin,
  input  wire logic                           overvolt_a_pin,
  input  wire logic                           overvolt_b_pin,
  input  wire logic                           bus_sto_cmd,
  input  wire logic                           bus_ss1_cmd,
  input  wire logic                           on_cmd,
  input  wire logic                           reset_ack,
  input  wire logic                           internal_fault,
  input  wire logic                           external_fault,
  input  wire logic                           drive_fault,
  output logic                                torque_permit,
  output logic                                motor_run,
  output logic                                ss1_active,
  output logic [15:0]                         ramp_left,
  output logic                                torque_off_warning,
  output logic                                channel_fault_warning,
  output logic                                protection_mode
);
  import sto_ss1_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES);

  state_type    state_q;
  state_type    state_d;
  logic [3:0]   sync1_q;
  logic [3:0]   sync2_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic         tick_q;
  logic [1:0]   filt_q;
  logic [9:0]   disc_cnt_q;
  logic [3:0]   func_q;
  logic         fb_en_q;
  logic         auto_q;
  logic [15:0]  delay_q;
  logic [6:0]   delta_q;
  logic         sw_ack_q;
  logic         wr_pend_q;
  logic [11:0]  wr_addr_q;
  logic [16:0]  stop_cnt_q;
  logic         di_trig_q;
  logic [15:0]  ramp_left_q;
  logic         chan_flt_q;
  logic         prot_q;
  logic [22:0]  margin_prod;
  logic [15:0]  ramp_len;
  logic         di_sto_mode;
  logic         di_ss1_mode;
  logic         di_low;
  logic         fb_sto;
  logic         fb_ss1;
  logic         sto_any;
  logic         ss1_any;
  logic         all_idle;
  logic         expired;
  logic         quit;
  logic         ack;
  logic         addr_ok;
  logic [31:0]  rd_word;

  // pins are asynchronous; only sync2_q feeds logic
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else if (clk_en)
    begin
      sync1_q <= {overvolt_b_pin, overvolt_a_pin, chan_b_pin, chan_a_pin};
      sync2_q <= sync1_q;
    end

  // single millisecond tick for every safety timer
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end
    else if (clk_en)
    begin
      tick_q <= (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));
      if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1))
        tick_cnt_q <= '0;
      else
        tick_cnt_q <= tick_cnt_q + 1'b1;
    end

  // high passes at once, low only after the test-pulse window
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_deb
      logic [7:0] low_cnt_q;
      always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
          low_cnt_q <= 8'h00;
          filt_q[g] <= 1'b0;
        end
        else if (clk_en)
        begin
          if (sync2_q[g])
          begin
            low_cnt_q <= 8'h00;
            filt_q[g] <= 1'b1;
          end
          else if (tick_q && low_cnt_q != DEB_LIMIT)
            low_cnt_q <= low_cnt_q + 8'h01;
          else if (low_cnt_q == DEB_LIMIT)
            filt_q[g] <= 1'b0;
        end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      disc_cnt_q <= 10'h000;
    else if (clk_en)
    begin
      if (filt_q[0] == filt_q[1])
        disc_cnt_q <= 10'h000;
      else if (tick_q && disc_cnt_q != DISC_LIMIT)
        disc_cnt_q <= disc_cnt_q + 10'h001;
    end

  assign ack = reset_ack | sw_ack_q;

  // sticky flags: a new set wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      chan_flt_q <= 1'b0;
      prot_q     <= 1'b0;
    end
    else if (clk_en)
    begin
      if (disc_cnt_q == DISC_LIMIT)
        chan_flt_q <= 1'b1;
      else if (ack && filt_q == 2'b11)
        chan_flt_q <= 1'b0;
      if (sync2_q[2] | sync2_q[3])
        prot_q <= 1'b1;
      else if (ack)
        prot_q <= 1'b0;
    end

  assign di_sto_mode = (func_q == FUNC_STO);
  assign di_ss1_mode = (func_q == FUNC_SS1);
  assign di_low      = ~filt_q[0] | ~filt_q[1];
  assign fb_sto      = fb_en_q & bus_sto_cmd;
  assign fb_ss1      = fb_en_q & bus_ss1_cmd;
  assign sto_any     = (di_sto_mode & di_low) | fb_sto | internal_fault | external_fault | prot_q;
  assign ss1_any     = (di_ss1_mode & di_low) | fb_ss1;
  assign all_idle    = ~sto_any & ~ss1_any;
  assign expired     = stop_cnt_q > {1'b0, delay_q};
  assign quit        = ~fb_ss1 & ~(di_ss1_mode & di_low) & (auto_q | ~di_trig_q);

  always_comb
  begin
    state_d = state_q;
    if (sto_any)
      state_d = S_STO;
    else
      case (state_q)
        S_STO:
          if (all_idle)
            state_d = auto_q ? S_READY : S_WAIT_ACK;
        S_WAIT_ACK:
          if (!all_idle)
            state_d = S_STO;
          else if (ack)
            state_d = S_READY;
        S_READY:
          if (ss1_any)
            state_d = S_SS1;
          else if (on_cmd)
            state_d = S_RUN;
        S_RUN:
          if (ss1_any)
            state_d = S_SS1;
          else if (!on_cmd)
            state_d = S_READY;
        S_SS1:
          if (drive_fault || expired)
            state_d = S_STO;
          else if (quit)
            state_d = S_READY;
        default:
          state_d = S_STO;
      endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      state_q <= S_STO;
    else if (clk_en)
      state_q <= state_d;

  // stop timer, restarted from zero on every entry
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      stop_cnt_q <= 17'h0_0000;
      di_trig_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state_d != S_SS1 || state_q != S_SS1)
        stop_cnt_q <= 17'h0_0000;
      else if (tick_q && !expired)
        stop_cnt_q <= stop_cnt_q + 17'h0_0001;
      if (state_d != S_SS1)
        di_trig_q <= 1'b0;
      else if (di_ss1_mode && di_low)
        di_trig_q <= 1'b1;
    end

  // ramp aims at standstill a margin before expiry
  assign margin_prod = delay_q * delta_q;
  assign ramp_len    = delay_q - 16'(margin_prod / PERCENT);

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ramp_left_q <= 16'h0000;
    else if (clk_en)
    begin
      if (state_d != S_SS1)
        ramp_left_q <= 16'h0000;
      else if (state_q != S_SS1)
        ramp_left_q <= ramp_len;
      else if (tick_q && ramp_left_q != 16'h0000)
        ramp_left_q <= ramp_left_q - 16'h0001;
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      torque_permit         <= 1'b0;
      motor_run             <= 1'b0;
      ss1_active            <= 1'b0;
      torque_off_warning    <= 1'b1;
      channel_fault_warning <= 1'b0;
      protection_mode       <= 1'b0;
    end
    else if (clk_en)
    begin
      torque_permit         <= (state_d != S_STO);
      motor_run             <= (state_d == S_RUN) || (state_d == S_SS1);
      ss1_active            <= (state_d == S_SS1);
      torque_off_warning    <= (state_d == S_STO);
      channel_fault_warning <= chan_flt_q;
      protection_mode       <= prot_q;
    end

  assign ramp_left = ramp_left_q;

  // AHB-Lite slave: zero wait states, always OKAY
  assign addr_ok = hsel & hready & htrans[1];

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (haddr)
      ADDR_CTRL:
      begin
        rd_word[CTRL_FUNC_LSB +: 4] = func_q;
        rd_word[CTRL_FB_EN]         = fb_en_q;
        rd_word[CTRL_AUTO]          = auto_q;
      end
      ADDR_DELAY:
        rd_word[15:0] = delay_q;
      ADDR_DELTA:
        rd_word[6:0] = delta_q;
      ADDR_STATUS:
      begin
        rd_word[ST_STATE_LSB +: 3] = state_q;
        rd_word[ST_CHAN_A]         = filt_q[0];
        rd_word[ST_CHAN_B]         = filt_q[1];
        rd_word[ST_CHAN_FLT]       = chan_flt_q;
        rd_word[ST_PROT]           = prot_q;
        rd_word[ST_PERMIT]         = torque_permit;
      end
      default:
        rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_pend_q <= addr_ok & hwrite;
      if (addr_ok)
        wr_addr_q <= haddr;
      if (addr_ok && !hwrite)
        hrdata <= rd_word;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      func_q   <= FUNC_RESET;
      fb_en_q  <= 1'b0;
      auto_q   <= 1'b0;
      delay_q  <= DELAY_RESET;
      delta_q  <= DELTA_RESET;
      sw_ack_q <= 1'b0;
    end
    else if (clk_en)
    begin
      sw_ack_q <= 1'b0;
      if (wr_pend_q)
        case (wr_addr_q)
          ADDR_CTRL:
          begin
            func_q   <= hwdata[CTRL_FUNC_LSB +: 4];
            fb_en_q  <= hwdata[CTRL_FB_EN];
            auto_q   <= hwdata[CTRL_AUTO];
            sw_ack_q <= hwdata[CTRL_ACK];
          end
          ADDR_DELAY:
            delay_q <= hwdata[15:0];
          ADDR_DELTA:
            delta_q <= (hwdata[6:0] > DELTA_MAX) ? DELTA_MAX : hwdata[6:0];  // margin capped at whole delay
          default:
            sw_ack_q <= 1'b0;
        endcase
    end

  property p_di_sto;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && di_sto_mode && di_low) |=> (state_q == S_STO && !torque_permit);
  endproperty
  a_di_sto: assert property (p_di_sto) else $error("input request did not remove torque");

  property p_fb_sto;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && fb_sto) |=> (state_q == S_STO);
  endproperty
  a_fb_sto: assert property (p_fb_sto) else $error("fieldbus torque-off ignored");

  property p_exit;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && state_q == S_STO && !all_idle) |=> (state_q == S_STO);
  endproperty
  a_exit: assert property (p_exit) else $error("left torque-off with a source active");

  property p_auto;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && state_q == S_STO && all_idle && auto_q) |=> (state_q == S_READY);
  endproperty
  a_auto: assert property (p_auto) else $error("automatic restart not ready");

  property p_manual;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == S_WAIT_ACK && !ack) |=> (state_q != S_RUN && state_q != S_READY);
  endproperty
  a_manual: assert property (p_manual) else $error("manual restart without acknowledge");

  property p_expire;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && state_q == S_SS1 && expired) |=> (state_q == S_STO && !torque_permit);
  endproperty
  a_expire: assert property (p_expire) else $error("expiry did not force torque-off");

  property p_coast;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && state_q == S_SS1 && drive_fault) |=> (state_q == S_STO);
  endproperty
  a_coast: assert property (p_coast) else $error("drive fault did not coast");

  property p_fault;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && (internal_fault || external_fault)) |=> (state_q == S_STO);
  endproperty
  a_fault: assert property (p_fault) else $error("fault did not force torque-off");

  property p_early;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == S_SS1 && $past(state_q) == S_SS1 && state_d == S_STO && !sto_any && !drive_fault)
        |-> (stop_cnt_q > {1'b0, delay_q});
  endproperty
  a_early: assert property (p_early) else $error("stop timer expired early");

  property p_prot;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && (sync2_q[2] || sync2_q[3])) |=> prot_q ##1 (!clk_en || state_q == S_STO);
  endproperty
  a_prot: assert property (p_prot) else $error("overvoltage not protected");

  property p_deb;
    @(posedge hclk) disable iff (!hresetn)
      $fell(filt_q[0]) |-> (!$past(sync2_q[0]) && $past(g_deb[0].low_cnt_q) == DEB_LIMIT);
  endproperty
  a_deb: assert property (p_deb) else $error("channel fell before pulse window");

  property p_disc;
    @(posedge hclk) disable iff (!hresetn)
      $rose(chan_flt_q) |-> ($past(disc_cnt_q) == DISC_LIMIT);
  endproperty
  a_disc: assert property (p_disc) else $error("channel fault before window");

endmodule // sto_ss1_core

// file: verilog/sto_ss1_pkg.sv
// Purpose: shared constants for the torque-off and timed-stop safety logic
// Assumes: 125 MHz hclk, 1 ms safety tick
// Notes:   register map is word aligned on AHB-Lite
package sto_ss1_pkg;

  localparam int CLK_PERIOD_NS  = 8;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEBOUNCE_MS    = 5;
  localparam int DEBOUNCE_TICKS = (DEBOUNCE_MS * 1000000) / TICK_PERIOD_NS;
  localparam int DISC_MS        = 500;
  localparam int DISC_TICKS     = (DISC_MS * 1000000) / TICK_PERIOD_NS;

  localparam logic [7:0] DEB_LIMIT  = 8'(DEBOUNCE_TICKS + 1);
  localparam logic [9:0] DISC_LIMIT = 10'(DISC_TICKS + 1);

  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_DELAY  = 12'h004;
  localparam logic [11:0] ADDR_DELTA  = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;

  localparam int CTRL_FUNC_LSB = 0;
  localparam int CTRL_FB_EN    = 4;
  localparam int CTRL_AUTO     = 5;
  localparam int CTRL_ACK      = 8;

  localparam logic [3:0]  FUNC_STO    = 4'h0;
  localparam logic [3:0]  FUNC_SS1    = 4'h9;
  localparam logic [3:0]  FUNC_RESET  = 4'hF;
  localparam logic [15:0] DELAY_RESET = 16'h03E8;
  localparam logic [6:0]  DELTA_RESET = 7'h0A;
  localparam logic [6:0]  DELTA_MAX   = 7'h64;
  localparam logic [22:0] PERCENT     = 23'h00_0064;

  localparam int ST_STATE_LSB = 0;
  localparam int ST_CHAN_A    = 3;
  localparam int ST_CHAN_B    = 4;
  localparam int ST_CHAN_FLT  = 5;
  localparam int ST_PROT      = 6;
  localparam int ST_PERMIT    = 7;

  typedef enum logic [2:0]
  {
    S_STO      = 3'b000,
    S_WAIT_ACK = 3'b001,
    S_READY    = 3'b011,
    S_RUN      = 3'b010,
    S_SS1      = 3'b110
  } state_type;

endpackage

// file: verif/safety_ctrl_model.sv
// Purpose: far-side safety controller driving both input channels and fieldbus commands
// Assumes: tasks are called just after a rising hclk edge
// Notes:   commands are levels, so a held level stands for the periodic resend
`timescale 1ns/1ns
module safety_ctrl_model (
  output logic chan_a_pin,
  output logic chan_b_pin,
  output logic overvolt_a_pin,
  output logic overvolt_b_pin,
  output logic bus_sto_cmd,
  output logic bus_ss1_cmd
);
  // channels start low so a disabled input function has something to ignore
  initial
  begin
    chan_a_pin     = 1'b0;
    chan_b_pin     = 1'b0;
    overvolt_a_pin = 1'b0;
    overvolt_b_pin = 1'b0;
    bus_sto_cmd    = 1'b0;
    bus_ss1_cmd    = 1'b0;
  end

  task set_chans(input logic a, input logic b);
    chan_a_pin <= a;
    chan_b_pin <= b;
  endtask

  // steady level held every cycle, never a one-shot
  task set_cmds(input logic sto, input logic ss1);
    bus_sto_cmd <= sto;
    bus_ss1_cmd <= ss1;
  endtask

  task set_ov(input logic a, input logic b);
    overvolt_a_pin <= a;
    overvolt_b_pin <= b;
  endtask
endmodule // safety_ctrl_model

// file: verif/tb.sv
// Purpose: self-checking bench for the torque-off and timed-stop logic
// Assumes: tick shortened to 8 cycles, so one ms is 8 hclk cycles
// Notes:   random delays and margins from a fixed-seed xorshift
`timescale 1ns/1ns
module tb;
  import sto_ss1_pkg::*;
  localparam int TK = 8;
  logic        hclk;
  logic        hresetn;
  logic        clk_en;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        chan_a_pin, chan_b_pin, overvolt_a_pin, overvolt_b_pin, bus_sto_cmd, bus_ss1_cmd;
  logic        on_cmd, reset_ack, internal_fault, external_fault, drive_fault;
  logic        torque_permit, motor_run, ss1_active, torque_off_warning, channel_fault_warning;
  logic        protection_mode;
  logic [15:0] ramp_left;
  logic [4:0]  outs;
  logic [31:0] seed;
  int          n_errors, total_checks, wc, d, p, t;

  assign outs = {protection_mode, channel_fault_warning, ss1_active, motor_run, torque_permit};

  sto_ss1_core #(.TICK_CYCLES(TK)) sto_ss1_core_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .chan_a_pin(chan_a_pin),
    .chan_b_pin(chan_b_pin), .overvolt_a_pin(overvolt_a_pin), .overvolt_b_pin(overvolt_b_pin),
    .bus_sto_cmd(bus_sto_cmd), .bus_ss1_cmd(bus_ss1_cmd), .on_cmd(on_cmd), .reset_ack(reset_ack),
    .internal_fault(internal_fault), .external_fault(external_fault), .drive_fault(drive_fault),
    .torque_permit(torque_permit), .motor_run(motor_run), .ss1_active(ss1_active), .ramp_left(ramp_left),
    .torque_off_warning(torque_off_warning), .channel_fault_warning(channel_fault_warning),
    .protection_mode(protection_mode));

  safety_ctrl_model safety_ctrl_model_inst (.chan_a_pin(chan_a_pin), .chan_b_pin(chan_b_pin),
    .overvolt_a_pin(overvolt_a_pin), .overvolt_b_pin(overvolt_b_pin), .bus_sto_cmd(bus_sto_cmd),
    .bus_ss1_cmd(bus_ss1_cmd));

  always #4 hclk = ~hclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // ramp is the delay less its percent margin, truncated
  function automatic int exp_ramp(input int dl, input int pc);
    return dl - (dl * pc) / 100;
  endfunction

  task complete_run();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // address phase held until hready, then data phase until hready
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] r;
    xfer(1'b1, a, v, r);
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask

  // bounded wait on one output, count kept in wc
  task wt(input int k, input logic v, input int lim);
    wc = 0;
    while (outs[k] !== v && wc < lim)
    begin
      @(posedge hclk);
      wc++;
    end
    chk(outs[k], v);
  endtask

  task hold(input int k, input logic v, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n)
    begin
      @(posedge hclk);
      if (outs[k] !== v)
        ok = 1'b0;
    end
    chk(ok, 1'b1);
  endtask

  task pulse_ack();
    reset_ack <= 1'b1;
    @(posedge hclk);
    reset_ack <= 1'b0;
  endtask

  task setup(input logic [31:0] ctrl);
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    wr(ADDR_CTRL, ctrl);
    pulse_ack();
    on_cmd <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask

  initial
  begin
    #240000;
    n_errors++;
    complete_run();
  end

  initial
  begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
    on_cmd = 0; reset_ack = 0; internal_fault = 0; external_fault = 0; drive_fault = 0;
    clk_en = 1;
    seed = 32'h3756_a29d;
    n_errors = 0;
    total_checks = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({torque_off_warning, torque_permit, ramp_left}, {2'b10, 16'h0000});
    rd_chk(ADDR_CTRL, 32'h0000_000F);
    rd_chk(ADDR_DELAY, 32'h0000_03E8);
    rd_chk(ADDR_DELTA, 32'h0000_000A);
    rd_chk(12'h010, 32'h0000_0000);
    rd_chk(ADDR_STATUS, 32'h0000_0081);
    wr(ADDR_DELTA, 32'h0000_0078);
    rd_chk(ADDR_DELTA, 32'h0000_0064);
    on_cmd <= 1'b1;
    hold(1, 1'b0, 20);
    pulse_ack();
    wt(1, 1'b1, 6);
    wr(ADDR_CTRL, 32'h0000_003F);
    hold(1, 1'b1, 80);
    safety_ctrl_model_inst.set_chans(1'b1, 1'b1);
    safety_ctrl_model_inst.set_cmds(1'b1, 1'b0);
    wt(0, 1'b0, 6);
    chk(torque_off_warning, 1'b1);
    on_cmd <= 1'b0;
    safety_ctrl_model_inst.set_cmds(1'b0, 1'b0);
    wt(0, 1'b1, 6);
    chk(motor_run, 1'b0);
    on_cmd <= 1'b1;
    wt(1, 1'b1, 6);
    repeat (3)
    begin
      d = 8 + int'(rnd() % 32);
      p = int'(rnd() % 101);
      wr(ADDR_DELAY, 32'(d));
      wr(ADDR_DELTA, 32'(p));
      safety_ctrl_model_inst.set_cmds(1'b0, 1'b1);
      wt(2, 1'b1, 6);
      t = wc;
      chk(ramp_left, 16'(exp_ramp(d, p)));
      wt(0, 1'b0, 400);
      t = t + wc;
      chk(t >= d * TK && t <= (d + 2) * TK + 4, 1'b1);
      safety_ctrl_model_inst.set_cmds(1'b0, 1'b0);
      wt(0, 1'b1, 6);
    end
    wr(ADDR_DELAY, 32'h0000_0028);
    wr(ADDR_DELTA, 32'h0000_0000);
    safety_ctrl_model_inst.set_cmds(1'b0, 1'b1);
    wt(2, 1'b1, 6);
    repeat (10) @(posedge hclk);
    chk(ramp_left == 16'h0026 || ramp_left == 16'h0027, 1'b1);
    safety_ctrl_model_inst.set_cmds(1'b0, 1'b0);
    wt(2, 1'b0, 6);
    chk(torque_permit, 1'b1);
    clk_en <= 1'b0;
    safety_ctrl_model_inst.set_cmds(1'b1, 1'b0);
    hold(0, 1'b1, 20);
    clk_en <= 1'b1;
    wt(0, 1'b0, 6);
    safety_ctrl_model_inst.set_cmds(1'b0, 1'b0);
    wt(0, 1'b1, 6);
    for (int k = 0; k < 4; k++)
    begin
      setup(32'h0000_003F);
      safety_ctrl_model_inst.set_cmds(1'b0, 1'b1);
      wt(2, 1'b1, 8);
      repeat (10) @(posedge hclk);
      case (k)
        0: safety_ctrl_model_inst.set_cmds(1'b1, 1'b1);
        1: drive_fault <= 1'b1;
        2: external_fault <= 1'b1;
        default: internal_fault <= 1'b1;
      endcase
      wt(0, 1'b0, 6);
      safety_ctrl_model_inst.set_cmds(1'b0, 1'b0);
      {drive_fault, external_fault, internal_fault} <= 3'b000;
    end
    setup(32'h0000_0020);
    wt(0, 1'b1, 80);
    safety_ctrl_model_inst.set_chans(1'b0, 1'b1);
    hold(0, 1'b1, 32);
    safety_ctrl_model_inst.set_chans(1'b1, 1'b1);
    hold(0, 1'b1, 60);
    safety_ctrl_model_inst.set_chans(1'b0, 1'b0);
    wt(0, 1'b0, 70);
    chk({torque_off_warning, channel_fault_warning}, 2'b10);
    safety_ctrl_model_inst.set_chans(1'b1, 1'b1);
    wt(0, 1'b1, 70);
    safety_ctrl_model_inst.set_chans(1'b1, 1'b0);
    wt(0, 1'b0, 70);
    chk(channel_fault_warning, 1'b0);
    wt(3, 1'b1, 4200);
    chk(wc > 3800, 1'b1);
    safety_ctrl_model_inst.set_chans(1'b1, 1'b1);
    setup(32'h0000_003F);
    safety_ctrl_model_inst.set_ov(1'b0, 1'b1);
    wt(4, 1'b1, 6);
    wt(0, 1'b0, 6);
    safety_ctrl_model_inst.set_ov(1'b0, 1'b0);
    setup(32'h0000_0009);
    wr(ADDR_DELAY, 32'h0000_001E);
    repeat (10) @(posedge hclk);
    safety_ctrl_model_inst.set_chans(1'b0, 1'b1);
    wt(2, 1'b1, 70);
    safety_ctrl_model_inst.set_chans(1'b1, 1'b1);
    wt(0, 1'b0, 330);
    complete_run();
  end
endmodule // tb
